// ---- core/lamp_pkg.sv ----
// ----------------------------------------------------------------
// shared constants of the status indicator block
// ----------------------------------------------------------------
package lamp_pkg;
   // system clock rate in hertz
   localparam int CLK_HZ = 10_000_000;
   // flash rates in hertz, power-up window in seconds
   localparam int SLOW_FLASH_HZ = 1;
   localparam int FAST_FLASH_HZ = 10;
   localparam int POWERUP_WINDOW_S = 10;
   // derived cycle counts: half periods of the flash patterns
   localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_HZ);
   localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_HZ);
   // power-up window length in clock cycles
   localparam int POWERUP_CYC = POWERUP_WINDOW_S * CLK_HZ;
   // scan engine defaults: cycles per beam and beams per scan
   localparam int BEAM_STEP_CYC = 16;
   localparam int NUM_BEAMS = 16;
   localparam int MIN_BEAMS = 2;

   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATE_OFS = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
   localparam logic [7:0] SCAN_COUNT_OFS = 8'h10;
   localparam logic [7:0] SCAN_BEAMS_OFS = 8'h14;

   // control register fields and reset value
   localparam int CTRL_SCAN_EN_BIT = 0;
   localparam logic CTRL_SCAN_EN_RST = 1'b1;
   // interrupt status and mask layout
   localparam int IRQ_W = 4;
   localparam int IRQ_SYNC_LOST = 0;
   localparam int IRQ_OUTPUT_OFF = 1;
   localparam int IRQ_ERROR = 2;
   localparam int IRQ_SCAN_DONE = 3;
   localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

   // pin vector positions, also the state register bit layout
   localparam int PIN_TX_PWR = 0;
   localparam int PIN_TX_ERR = 1;
   localparam int PIN_TX_RANGE = 2;
   localparam int PIN_TX_CH2 = 3;
   localparam int PIN_RX_PWR = 4;
   localparam int PIN_RX_ON = 5;
   localparam int PIN_RX_EXT = 6;
   localparam int PIN_RX_INT = 7;
   localparam int PIN_RX_WEAK = 8;
   localparam int PIN_RX_CH2 = 9;
   localparam int PIN_BEAM = 10;
   localparam int PIN_COUNT = 11;
   localparam int STATE_WINDOW_BIT = 11;
   localparam int STATE_SYNC_BIT = 12;
endpackage

// ---- core/timebase_if.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// flash phases and power-up window from the timebase
// ----------------------------------------------------------------
interface timebase_if;
   logic slow_phase; // toggles every slow half period
   logic fast_phase; // toggles every fast half period
   logic window_active; // high from reset until the window ends
   modport src (output slow_phase, output fast_phase, output window_active);
   modport snk (input slow_phase, input fast_phase, input window_active);
endinterface

// ---- core/flash_timebase.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// free-running flash counters and power-up window
// ----------------------------------------------------------------
module flash_timebase #(
   parameter int SLOW_HALF = lamp_pkg::SLOW_HALF_CYC,
   parameter int FAST_HALF = lamp_pkg::FAST_HALF_CYC,
   parameter int WINDOW = lamp_pkg::POWERUP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   timebase_if.src tb
);
   // counts must be at least one cycle
   if (SLOW_HALF < 1 || FAST_HALF < 1 || WINDOW < 1) begin : g_bad
      $error("flash_timebase: counts must be positive");
   end

   logic [31:0] slow_cnt_q; // slow half-period counter
   logic [31:0] fast_cnt_q; // fast half-period counter
   logic [31:0] win_cnt_q; // power-up window counter, saturates
   logic slow_q;
   logic fast_q;
   logic win_q;

   // slow phase: toggles each half period, restarts at reset
   always_ff @(posedge clk) begin
      if (rst) begin
         slow_cnt_q <= 32'h0000_0000;
         slow_q <= 1'b0;
      end else if (slow_cnt_q == 32'(SLOW_HALF - 1)) begin
         slow_cnt_q <= 32'h0000_0000;
         slow_q <= ~slow_q;
      end else begin
         slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
      end
   end

   // fast phase: same scheme, ten times quicker
   always_ff @(posedge clk) begin
      if (rst) begin
         fast_cnt_q <= 32'h0000_0000;
         fast_q <= 1'b0;
      end else if (fast_cnt_q == 32'(FAST_HALF - 1)) begin
         fast_cnt_q <= 32'h0000_0000;
         fast_q <= ~fast_q;
      end else begin
         fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
      end
   end

   // window: runs once after reset, then holds closed
   always_ff @(posedge clk) begin
      if (rst) begin
         win_cnt_q <= 32'h0000_0000;
         win_q <= 1'b1;
      end else if (win_q) begin
         win_cnt_q <= win_cnt_q + 32'h0000_0001;
         if (win_cnt_q == 32'(WINDOW - 1)) begin
            win_q <= 1'b0;
         end
      end
   end

   assign tb.slow_phase = slow_q;
   assign tb.fast_phase = fast_q;
   assign tb.window_active = win_q;
endmodule // flash_timebase

// ---- core/light_curtain_status_indicators.sv ----
// How it works
// - transmitter main lamp: dark, red, green
// - range reduced: aux lamp flashes ten seconds
// - aux lamp otherwise shows beam channel
// - receiver main lamp follows safety output pair
// - external error: slow red flash
// - internal error: fast red flash
// - output on, weak signal: slow green flash
// - receiver aux red on channel two, off
// - sync needs one of two sync beams
// - beams scanned first to last per scan
`timescale 1ns/1ps
module light_curtain_status_indicators #(
   parameter int SLOW_HALF = lamp_pkg::SLOW_HALF_CYC,
   parameter int FAST_HALF = lamp_pkg::FAST_HALF_CYC,
   parameter int WINDOW = lamp_pkg::POWERUP_CYC,
   parameter int BEAM_STEP = lamp_pkg::BEAM_STEP_CYC,
   parameter int BEAMS = lamp_pkg::NUM_BEAMS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   output logic irq,
   input wire logic tx_power_ok,
   input wire logic tx_device_error,
   input wire logic tx_range_reduced,
   input wire logic tx_beam_channel_two,
   input wire logic rx_power_ok,
   input wire logic rx_safety_output_pair_on,
   input wire logic rx_external_error,
   input wire logic rx_internal_error,
   input wire logic rx_weak_signal,
   input wire logic rx_beam_channel_two,
   input wire logic beam_clear,
   output logic tx_main_status_lamp_red,
   output logic tx_main_status_lamp_green,
   output logic tx_auxiliary_lamp,
   output logic rx_main_status_lamp_red,
   output logic rx_main_status_lamp_green,
   output logic rx_auxiliary_lamp
);
   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (BEAMS < lamp_pkg::MIN_BEAMS || BEAMS > 255 || BEAM_STEP < 1 || BEAM_STEP > 65535)
   begin : g_bad
      $error("light_curtain_status_indicators: beam parameters out of range");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int NP = lamp_pkg::PIN_COUNT;
   logic [NP-1:0] pin_raw; // pins gathered into one vector
   logic [NP-1:0] pin_meta_q; // first stage, read only by the second
   logic [NP-1:0] pin_s_q; // settled pin levels

   assign pin_raw = {beam_clear, rx_beam_channel_two, rx_weak_signal, rx_internal_error,
                     rx_external_error, rx_safety_output_pair_on, rx_power_ok,
                     tx_beam_channel_two, tx_range_reduced, tx_device_error, tx_power_ok};

   // two flops per pin; the lamps lag the pins by three cycles
   for (genvar i = 0; i < NP; i++) begin : g_sync
      always_ff @(posedge clk) begin
         if (rst) begin
            pin_meta_q[i] <= 1'b0;
            pin_s_q[i] <= 1'b0;
         end else begin
            pin_meta_q[i] <= pin_raw[i];
            pin_s_q[i] <= pin_meta_q[i];
         end
      end
   end

   logic tx_pwr, tx_err, tx_range, tx_ch2;
   logic rx_pwr, rx_on, rx_ext, rx_int, rx_weak, rx_ch2, beam_s;
   assign tx_pwr = pin_s_q[lamp_pkg::PIN_TX_PWR];
   assign tx_err = pin_s_q[lamp_pkg::PIN_TX_ERR];
   assign tx_range = pin_s_q[lamp_pkg::PIN_TX_RANGE];
   assign tx_ch2 = pin_s_q[lamp_pkg::PIN_TX_CH2];
   assign rx_pwr = pin_s_q[lamp_pkg::PIN_RX_PWR];
   assign rx_on = pin_s_q[lamp_pkg::PIN_RX_ON];
   assign rx_ext = pin_s_q[lamp_pkg::PIN_RX_EXT];
   assign rx_int = pin_s_q[lamp_pkg::PIN_RX_INT];
   assign rx_weak = pin_s_q[lamp_pkg::PIN_RX_WEAK];
   assign rx_ch2 = pin_s_q[lamp_pkg::PIN_RX_CH2];
   assign beam_s = pin_s_q[lamp_pkg::PIN_BEAM];

   // ----------------------------------------------------------------
   // flash timebase
   // ----------------------------------------------------------------
   timebase_if tb ();

   flash_timebase #(
      .SLOW_HALF(SLOW_HALF),
      .FAST_HALF(FAST_HALF),
      .WINDOW(WINDOW)
   ) u_timebase (
      .clk(clk),
      .rst(rst),
      .tb(tb.src)
   );

   // ----------------------------------------------------------------
   // registers written by software
   // ----------------------------------------------------------------
   logic scan_en_q; // scan engine runs while set
   logic [7:0] scan_beams_q; // beams per scan
   logic [lamp_pkg::IRQ_W-1:0] irq_mask_q; // interrupt mask
   logic [lamp_pkg::IRQ_W-1:0] irq_status_q; // sticky events
   logic [lamp_pkg::IRQ_W-1:0] events; // one-cycle event pulses
   logic wr_ctrl, wr_beams, wr_mask, wr_status;

   assign wr_ctrl = wr_en && addr == lamp_pkg::CTRL_OFS;
   assign wr_beams = wr_en && addr == lamp_pkg::SCAN_BEAMS_OFS;
   assign wr_mask = wr_en && addr == lamp_pkg::IRQ_MASK_OFS;
   assign wr_status = wr_en && addr == lamp_pkg::IRQ_STATUS_OFS;

   // control bits
   always_ff @(posedge clk) begin
      if (rst) begin
         scan_en_q <= lamp_pkg::CTRL_SCAN_EN_RST;
      end else if (wr_ctrl) begin
         scan_en_q <= wdata[lamp_pkg::CTRL_SCAN_EN_BIT];
      end
   end

   // beam count; below two there is no pair of sync beams, so clamp
   always_ff @(posedge clk) begin
      if (rst) begin
         scan_beams_q <= 8'(BEAMS);
      end else if (wr_beams) begin
         if (wdata[7:0] < 8'(lamp_pkg::MIN_BEAMS)) begin
            scan_beams_q <= 8'(lamp_pkg::MIN_BEAMS);
         end else begin
            scan_beams_q <= wdata[7:0];
         end
      end
   end

   // interrupt mask
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_q <= lamp_pkg::IRQ_RST;
      end else if (wr_mask) begin
         irq_mask_q <= wdata[lamp_pkg::IRQ_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // scan engine
   // ----------------------------------------------------------------
   logic [15:0] step_cnt_q; // cycles spent on the current beam
   logic [7:0] beam_idx_q; // beam under evaluation
   logic first_clear_q; // first sync beam was free this scan
   logic sync_ok_q; // last scan kept at least one sync beam free
   logic [31:0] scan_count_q; // completed scans
   logic step, scan_end, sync_now;

   assign step = scan_en_q && step_cnt_q == 16'(BEAM_STEP - 1);
   assign scan_end = step && beam_idx_q >= scan_beams_q - 8'h01;
   assign sync_now = first_clear_q | beam_s;

   // dwell counter per beam; held at zero while scanning is off
   always_ff @(posedge clk) begin
      if (rst || !scan_en_q || step) begin
         step_cnt_q <= 16'h0000;
      end else begin
         step_cnt_q <= step_cnt_q + 16'h0001;
      end
   end

   // beam pointer walks first to last, then wraps for the next scan
   always_ff @(posedge clk) begin
      if (rst) begin
         beam_idx_q <= 8'h00;
      end else if (scan_end) begin
         beam_idx_q <= 8'h00;
      end else if (step) begin
         beam_idx_q <= beam_idx_q + 8'h01;
      end
   end

   // sync beams are the first and the last of each scan
   always_ff @(posedge clk) begin
      if (rst) begin
         first_clear_q <= 1'b0;
         sync_ok_q <= 1'b0;
      end else begin
         if (step && beam_idx_q == 8'h00) begin
            first_clear_q <= beam_s;
         end
         if (scan_end) begin
            sync_ok_q <= sync_now;
         end
      end
   end

   // scan counter: its rate gives the response time
   always_ff @(posedge clk) begin
      if (rst) begin
         scan_count_q <= 32'h0000_0000;
      end else if (scan_end) begin
         scan_count_q <= scan_count_q + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // lamp drivers
   // ----------------------------------------------------------------
   // transmitter main lamp: power first, then error, else green
   always_ff @(posedge clk) begin
      if (rst || !tx_pwr) begin
         tx_main_status_lamp_red <= 1'b0;
         tx_main_status_lamp_green <= 1'b0;
      end else begin
         tx_main_status_lamp_red <= tx_err;
         tx_main_status_lamp_green <= !tx_err;
      end
   end

   // transmitter aux lamp: flashes in the window only when range is reduced
   always_ff @(posedge clk) begin
      if (rst || !tx_pwr) begin
         tx_auxiliary_lamp <= 1'b0;
      end else if (tb.window_active && tx_range) begin
         tx_auxiliary_lamp <= tb.slow_phase;
      end else begin
         tx_auxiliary_lamp <= tx_ch2;
      end
   end

   // receiver main lamp: internal error outranks external, errors outrank output
   always_ff @(posedge clk) begin
      if (rst || !rx_pwr) begin
         rx_main_status_lamp_red <= 1'b0;
         rx_main_status_lamp_green <= 1'b0;
      end else if (rx_int) begin
         rx_main_status_lamp_red <= tb.fast_phase;
         rx_main_status_lamp_green <= 1'b0;
      end else if (rx_ext) begin
         rx_main_status_lamp_red <= tb.slow_phase;
         rx_main_status_lamp_green <= 1'b0;
      end else if (!rx_on) begin
         rx_main_status_lamp_red <= 1'b1;
         rx_main_status_lamp_green <= 1'b0;
      end else begin
         rx_main_status_lamp_red <= 1'b0;
         // weak signal trades steady green for a slow flash
         rx_main_status_lamp_green <= rx_weak ? tb.slow_phase : 1'b1;
      end
   end

   // receiver aux lamp: red only on channel two with the outputs off
   always_ff @(posedge clk) begin
      if (rst || !rx_pwr) begin
         rx_auxiliary_lamp <= 1'b0;
      end else begin
         rx_auxiliary_lamp <= rx_ch2 && !rx_on;
      end
   end

   // ----------------------------------------------------------------
   // events and interrupt
   // ----------------------------------------------------------------
   logic rx_on_prev_q; // output state one cycle ago
   logic err_prev_q; // any error one cycle ago
   logic any_err;

   assign any_err = tx_err | rx_ext | rx_int;

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_on_prev_q <= 1'b0;
         err_prev_q <= 1'b0;
      end else begin
         rx_on_prev_q <= rx_on;
         err_prev_q <= any_err;
      end
   end

   always_comb begin
      events = '0;
      events[lamp_pkg::IRQ_SYNC_LOST] = scan_end && !sync_now;
      events[lamp_pkg::IRQ_OUTPUT_OFF] = rx_on_prev_q && !rx_on;
      events[lamp_pkg::IRQ_ERROR] = any_err && !err_prev_q;
      events[lamp_pkg::IRQ_SCAN_DONE] = scan_end;
   end

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status_q <= lamp_pkg::IRQ_RST;
      end else if (wr_status) begin
         irq_status_q <= (irq_status_q & ~wdata[lamp_pkg::IRQ_W-1:0]) | events;
      end else begin
         irq_status_q <= irq_status_q | events;
      end
   end

   // level interrupt, one cycle behind the status bits
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // read port: data valid only in the cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst || !rd_en) begin
         rdata <= 32'h0000_0000;
      end else begin
         case (addr)
            lamp_pkg::CTRL_OFS: rdata <= {31'h0000_0000, scan_en_q};
            lamp_pkg::STATE_OFS: rdata <= {19'h0_0000, sync_ok_q, tb.window_active, pin_s_q};
            lamp_pkg::IRQ_STATUS_OFS: rdata <= {28'h000_0000, irq_status_q};
            lamp_pkg::IRQ_MASK_OFS: rdata <= {28'h000_0000, irq_mask_q};
            lamp_pkg::SCAN_COUNT_OFS: rdata <= scan_count_q;
            lamp_pkg::SCAN_BEAMS_OFS: rdata <= {24'h00_0000, scan_beams_q};
            default: rdata <= 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence rx_live_s;
      rx_pwr && !rx_int && !rx_ext;
   endsequence

   sequence scan_blocked_s;
      scan_end && !sync_now;
   endsequence

   tx_main_lamp_a: assert property (
      !tx_pwr |=> !tx_main_status_lamp_red && !tx_main_status_lamp_green)
      else $error("tx main lamp lit while unpowered");
   tx_error_red_a: assert property (
      tx_pwr && tx_err |=> tx_main_status_lamp_red && !tx_main_status_lamp_green)
      else $error("tx main lamp not red on error");
   tx_aux_flash_a: assert property (
      tx_pwr && tx_range && tb.window_active |=> tx_auxiliary_lamp == $past(tb.slow_phase))
      else $error("tx aux lamp not flashing in window");
   tx_aux_channel_a: assert property (
      tx_pwr && !(tb.window_active && tx_range) |=> tx_auxiliary_lamp == $past(tx_ch2))
      else $error("tx aux lamp does not show channel");
   rx_output_lamp_a: assert property (
      rx_live_s ##0 !rx_on |=> rx_main_status_lamp_red && !rx_main_status_lamp_green)
      else $error("rx main lamp not red with outputs off");
   rx_ext_flash_a: assert property (
      rx_pwr && rx_ext && !rx_int |=> rx_main_status_lamp_red == $past(tb.slow_phase))
      else $error("rx lamp not slow red on external error");
   rx_int_flash_a: assert property (
      rx_pwr && rx_int |=> rx_main_status_lamp_red == $past(tb.fast_phase)
                           && !rx_main_status_lamp_green)
      else $error("rx lamp not fast red on internal error");
   rx_weak_flash_a: assert property (
      rx_live_s ##0 rx_on |=> rx_main_status_lamp_green == ($past(rx_weak) ?
                              $past(tb.slow_phase) : 1'b1))
      else $error("rx green lamp wrong for signal strength");
   rx_aux_lamp_a: assert property (
      rx_pwr |=> rx_auxiliary_lamp == ($past(rx_ch2) && !$past(rx_on)))
      else $error("rx aux lamp wrong");
   sync_lost_a: assert property (
      scan_blocked_s |=> !sync_ok_q && irq_status_q[lamp_pkg::IRQ_SYNC_LOST])
      else $error("blocked sync beams not flagged");
   scan_wrap_a: assert property (
      scan_end |=> beam_idx_q == 8'h00 && scan_count_q == $past(scan_count_q) + 32'h0000_0001)
      else $error("scan did not wrap to the first beam");
   window_once_a: assert property (
      !tb.window_active |=> !tb.window_active)
      else $error("power-up window reopened without reset");
   irq_level_a: assert property (
      |(irq_status_q & irq_mask_q) |=> irq)
      else $error("interrupt not raised for unmasked status");
endmodule // light_curtain_status_indicators

// ---- verification/lamp_observer.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// operator model: watches one lamp and times its flashing
// ----------------------------------------------------------------
module lamp_observer (
   input wire logic clk,
   input wire logic rst,
   input wire logic lamp,
   output int half_len,
   output int toggles
);
   logic last_q; // lamp level seen at the previous edge
   int run_q; // cycles the lamp has held its level
   // a person sees only changes; the length of each steady run gives the rate
   always_ff @(posedge clk) begin
      if (rst) begin
         last_q <= 1'b0;
         run_q <= 0;
         half_len <= 0;
         toggles <= 0;
      end else begin
         last_q <= lamp;
         run_q <= (lamp !== last_q) ? 1 : run_q + 1;
         if (lamp !== last_q) begin
            half_len <= run_q;
            toggles <= toggles + 1;
         end
      end
   end
endmodule // lamp_observer

// ---- verification/light_curtain_status_indicators_bench.sv ----
`timescale 1ns/1ps
module light_curtain_status_indicators_bench;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, obs_rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd_q;
   logic [10:0] pin = 11'h405; // tx powered, range reduced, beam clear
   logic irq, tmr, tmg, ta, rmr, rmg, ra;
   logic [1:0] sel = 2'd0; // which lamp the operator watches
   wire logic obs_lamp = (sel == 2'd0) ? ta : ((sel == 2'd1) ? rmr : rmg);
   int half_len, toggles, n_mismatch = 0, check_count = 0;
   initial forever #50 clk = ~clk;
   // small counts keep the run short: slow half 10, fast half 2, window 50
   light_curtain_status_indicators #(.SLOW_HALF(10), .FAST_HALF(2), .WINDOW(50),
      .BEAM_STEP(2), .BEAMS(4)) u_dut (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
      .tx_power_ok(pin[0]), .tx_device_error(pin[1]), .tx_range_reduced(pin[2]),
      .tx_beam_channel_two(pin[3]), .rx_power_ok(pin[4]),
      .rx_safety_output_pair_on(pin[5]), .rx_external_error(pin[6]),
      .rx_internal_error(pin[7]), .rx_weak_signal(pin[8]), .rx_beam_channel_two(pin[9]),
      .beam_clear(pin[10]), .tx_main_status_lamp_red(tmr), .tx_main_status_lamp_green(tmg),
      .tx_auxiliary_lamp(ta), .rx_main_status_lamp_red(rmr),
      .rx_main_status_lamp_green(rmg), .rx_auxiliary_lamp(ra));
   lamp_observer u_obs (.clk(clk), .rst(obs_rst), .lamp(obs_lamp), .half_len(half_len),
      .toggles(toggles));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // pins pass two sync flops and a lamp flop, so give them four edges
   task automatic set_pins(input logic [10:0] v);
      @(posedge clk);
      pin <= v;
      repeat (4) @(posedge clk);
      #1; // look once the lamp and status flops have settled
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 rd_q = rdata; // data stand only in the cycle after the strobe
   endtask
   // watch one lamp from a clean start for a few flash periods
   task automatic flash(input logic [10:0] v, input logic [1:0] s);
      set_pins(v);
      sel = s;
      obs_rst = 1'b1;
      @(posedge clk);
      obs_rst <= 1'b0;
      repeat (45) @(posedge clk);
      #1;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic tx_lamps;
      repeat (40) @(posedge clk);
      #1 chk("tx aux half", half_len, 10);
      repeat (30) @(posedge clk);
      #1 chk("tx aux ch1", ta, 0);
      // two on-off flashes inside the window, then the lamp rests
      chk("tx aux toggles", toggles, 4);
      set_pins(11'h60d);
      chk("tx aux ch2", ta, 1);
      set_pins(11'h404);
      chk("tx main off", {tmr, tmg}, 2'b00);
      set_pins(11'h407);
      chk("tx main err", {tmr, tmg}, 2'b10);
      set_pins(11'h405);
      chk("tx main ok", {tmr, tmg}, 2'b01);
   endtask
   task automatic rx_lamps;
      set_pins(11'h61d);
      chk("rx off ch2", {rmr, rmg, ra}, 3'b101);
      set_pins(11'h63d);
      chk("rx on ch2", {rmr, rmg, ra}, 3'b010);
      set_pins(11'h415);
      chk("rx off ch1", {rmr, rmg, ra}, 3'b100);
      set_pins(11'h405);
      chk("rx dark", {rmr, rmg, ra}, 3'b000);
      flash(11'h455, 2'd1);
      chk("ext err half", half_len, 10);
      flash(11'h4d5, 2'd1); // internal error outranks external
      chk("int err half", half_len, 2);
      flash(11'h535, 2'd2);
      chk("weak half", half_len, 10);
   endtask
   task automatic regs_scan;
      logic [31:0] c0;
      rd(8'h20);
      chk("unmapped", rd_q, 32'h0000_0000);
      rd(lamp_pkg::IRQ_MASK_OFS);
      chk("mask reset", rd_q, 32'h0000_0000);
      wr(lamp_pkg::IRQ_STATUS_OFS, 32'h0000_000f); // drop events of earlier scenarios
      wr(lamp_pkg::IRQ_MASK_OFS, 32'h0000_0004); // only the error event
      set_pins(11'h417);
      chk("irq raised", irq, 1);
      rd(lamp_pkg::IRQ_STATUS_OFS);
      chk("off and error events", rd_q[2:1], 2'b11);
      wr(lamp_pkg::IRQ_STATUS_OFS, 32'h0000_000f);
      repeat (3) @(posedge clk);
      #1 chk("irq cleared", irq, 0);
      set_pins(11'h015); // both sync beams blocked
      wr(lamp_pkg::IRQ_STATUS_OFS, 32'h0000_000f);
      repeat (20) @(posedge clk);
      rd(lamp_pkg::STATE_OFS);
      chk("sync low", rd_q[12], 0);
      rd(lamp_pkg::IRQ_STATUS_OFS);
      chk("sync lost", rd_q[0], 1);
      chk("scan done", rd_q[3], 1);
      set_pins(11'h415);
      repeat (20) @(posedge clk);
      rd(lamp_pkg::STATE_OFS);
      chk("sync ok", rd_q[12:0], 13'h1415);
      rd(lamp_pkg::SCAN_COUNT_OFS);
      c0 = rd_q;
      repeat (78) @(posedge clk);
      rd(lamp_pkg::SCAN_COUNT_OFS);
      chk("scans in 80", rd_q - c0, 10);
      wr(lamp_pkg::SCAN_BEAMS_OFS, 32'h0000_0001); // below two is clamped
      rd(lamp_pkg::SCAN_BEAMS_OFS);
      chk("beams clamp", rd_q, 32'h0000_0002);
      wr(lamp_pkg::CTRL_OFS, 32'h0000_0000); // stop the scan engine
      rd(lamp_pkg::SCAN_COUNT_OFS);
      c0 = rd_q;
      repeat (20) @(posedge clk);
      rd(lamp_pkg::SCAN_COUNT_OFS);
      chk("scan halted", rd_q, c0);
   endtask
   task automatic mid_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("lamps in reset", {tmr, tmg, ta, rmr, rmg, ra}, 6'b000000);
      @(posedge clk);
      rst <= 1'b0;
      // pins need two edges through the synchronisers, so lamps stay dark
      repeat (2) @(posedge clk);
      #1 chk("lamps after reset", {tmr, tmg, ta, rmr, rmg, ra}, 6'b000000);
      rd(lamp_pkg::STATE_OFS);
      chk("window reopened", rd_q[11], 1);
   endtask
   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      obs_rst <= 1'b0;
      tx_lamps();
      rx_lamps();
      regs_scan();
      mid_reset();
      summarize();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule // light_curtain_status_indicators_bench
